/* rtl/irc_defs.svh */
// Constants for the isochronous receive context control block.
// Assumes byte offsets inside the controller's memory window.
`ifndef IRC_DEFS_SVH
`define IRC_DEFS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define IRC_REGION       4'h4
`define IRC_SET_OFS      5'h00
`define IRC_CLR_OFS      5'h04
`define IRC_WR_MASK      32'hF000901F
`define IRC_RD_MASK      32'hF0009CFF

// ----------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------
`define IRC_B_PACK       31
`define IRC_B_KEEP       30
`define IRC_B_CME        29
`define IRC_B_MULTI      28
`define IRC_B_RUN        15
`define IRC_B_WAKE       12
`define IRC_B_DEAD       11
`define IRC_B_ACTIVE     10

// ----------------------------------------------------------------------
// Completion codes and speeds
// ----------------------------------------------------------------------
`define IRC_EVT_LONG     5'h02
`define IRC_EVT_OVERRUN  5'h05
`define IRC_EVT_DESC_RD  5'h06
`define IRC_EVT_DATA_WR  5'h08
`define IRC_EVT_UNKNOWN  5'h0E
`define IRC_ACK_COMPLETE 5'h11
`define IRC_ACK_DATA_ERR 5'h1D
`define IRC_SPD_S100     3'h0
`define IRC_SPD_S200     3'h1
`define IRC_SPD_S400     3'h2

`endif

/* rtl/irc_pkg.sv */
// Types shared by the receive context control modules.
// Assumes irc_defs.svh supplies the numeric constants.
package irc_pkg;
    typedef enum logic [1:0] {
        IRC_IDLE  = 2'b00,
        IRC_BODY  = 2'b01,
        IRC_TRAIL = 2'b11
    } irc_state_t;
endpackage

/* rtl/irc_ctx_if.sv */
// Carrier between the receive core and one context's control register.
// Assumes a single clock domain.
`timescale 1ns/1ps
interface irc_ctx_if;
    logic        sw_set;
    logic        sw_clr;
    logic [31:0] wdata;
    logic        desc_fetch;
    logic        fatal;
    logic [4:0]  fatal_code;
    logic        pkt_done;
    logic [2:0]  pkt_spd;
    logic [4:0]  pkt_evt;
    logic        cycle_hit;
    logic [31:0] ctrl;

    modport core (output sw_set, sw_clr, wdata, desc_fetch, fatal, fatal_code,
                  pkt_done, pkt_spd, pkt_evt, cycle_hit, input ctrl);
    modport ctx  (input sw_set, sw_clr, wdata, desc_fetch, fatal, fatal_code,
                  pkt_done, pkt_spd, pkt_evt, cycle_hit, output ctrl);
endinterface

/* rtl/irc_ctx.sv */
// Control and status register of one isochronous receive context.
// Assumes the core delivers one-cycle strobes on the carrier.
`timescale 1ns/1ps
`include "irc_defs.svh"
module irc_ctx (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Core side
    irc_ctx_if.ctx   bus
);
    logic [31:0] set_bits;
    logic [31:0] clr_bits;
    logic [3:0]  mode_reg;
    logic        run_reg;
    logic        wake_reg;
    logic        dead_reg;
    logic        active_reg;
    logic        active_next;
    logic [2:0]  spd_reg;
    logic [4:0]  evt_reg;

    assign set_bits = bus.sw_set ? (bus.wdata & `IRC_WR_MASK) : 32'h00000000;
    assign clr_bits = bus.sw_clr ? (bus.wdata & `IRC_WR_MASK) : 32'h00000000;

    // Running needs run, no fatal error, and the start cycle reached if asked.
    assign active_next = run_reg && !dead_reg && !bus.fatal &&
                         (active_reg || !mode_reg[1] || bus.cycle_hit); // [RULE8] [RULE16]

    // ------------------------------------------------------------------
    // Mode bits
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mode_reg <= 4'h0;
        end else begin
            mode_reg <= (mode_reg | set_bits[31:28]) & ~clr_bits[31:28];
            if (active_next && !active_reg) begin
                mode_reg[1] <= 1'b0; // [RULE9]
            end
        end
    end

    // ------------------------------------------------------------------
    // Run, wake, dead, active
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            run_reg <= 1'b0;
        end else begin
            run_reg <= (run_reg | set_bits[`IRC_B_RUN]) & ~clr_bits[`IRC_B_RUN]; // [RULE13]
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wake_reg <= 1'b0;
        end else if (set_bits[`IRC_B_WAKE]) begin
            wake_reg <= 1'b1; // [RULE14]
        end else if (bus.desc_fetch || clr_bits[`IRC_B_WAKE]) begin
            wake_reg <= 1'b0; // [RULE14]
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dead_reg <= 1'b0;
        end else if (bus.fatal && run_reg) begin
            dead_reg <= 1'b1; // [RULE15]
        end else if (!run_reg) begin
            dead_reg <= 1'b0; // [RULE15]
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            active_reg <= 1'b0;
        end else begin
            active_reg <= active_next; // [RULE16]
        end
    end

    // ------------------------------------------------------------------
    // Speed and completion code
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            spd_reg <= `IRC_SPD_S100;
            evt_reg <= 5'h00;
        end else if (bus.fatal) begin
            evt_reg <= bus.fatal_code;
            spd_reg <= bus.pkt_done ? bus.pkt_spd : spd_reg; // [RULE17]
        end else if (bus.pkt_done) begin
            spd_reg <= bus.pkt_spd; // [RULE17]
            evt_reg <= bus.pkt_evt;
        end else begin
            evt_reg <= (evt_reg | set_bits[4:0]) & ~clr_bits[4:0];
        end
    end

    assign bus.ctrl = {mode_reg, 12'h000, run_reg, 2'b00, wake_reg, dead_reg,
                       active_reg, 2'b00, spd_reg, evt_reg}; // [RULE23]

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_run_sw_only: assert property (@(posedge clk) disable iff (!reset_n) // [RULE13]
        (!bus.sw_set && !bus.sw_clr) |=> $stable(run_reg))
        else $error("run changed without a software write");
    a_wake_fetch: assert property (@(posedge clk) disable iff (!reset_n) // [RULE14]
        (bus.desc_fetch && !set_bits[`IRC_B_WAKE]) |=> !wake_reg)
        else $error("wake not cleared by descriptor fetch");
    a_dead_fatal: assert property (@(posedge clk) disable iff (!reset_n) // [RULE15]
        (bus.fatal && run_reg) |=> dead_reg ##0 !active_reg)
        else $error("fatal error did not kill the context");
    a_dead_norun: assert property (@(posedge clk) disable iff (!reset_n) // [RULE15]
        !run_reg |=> !dead_reg)
        else $error("dead stayed set with run clear");
    a_active_run: assert property (@(posedge clk) disable iff (!reset_n) // [RULE16]
        !run_reg |=> !active_reg)
        else $error("active without run");
    a_cme_clear: assert property (@(posedge clk) disable iff (!reset_n) // [RULE9]
        $rose(active_reg) |-> !mode_reg[1])
        else $error("start-on-cycle enable left set after start");
    a_cycle_wait: assert property (@(posedge clk) disable iff (!reset_n) // [RULE8]
        (mode_reg[1] && !active_reg && !bus.cycle_hit) |=> !active_reg)
        else $error("context started before its cycle");
endmodule

/* rtl/irc_core.sv */
// Eight isochronous receive DMA contexts: control registers and receive steering.
// Summary of operation
// [RULE1] Pack mode writes packets back to back.
// [RULE2] Per-packet mode closes one buffer per packet.
// [RULE3] Multi-channel use requires pack mode set.
// [RULE4] Software keeps mode bits steady while running.
// [RULE5] Keep-header stores the header before payload.
// [RULE6] Kept packets end with status and cycle_start_time.
// [RULE7] Without keep-header only payload is stored.
// [RULE8] Start-on-cycle waits for matching bus cycle.
// [RULE9] Start-on-cycle enable clears once context starts.
// [RULE10] Multi-channel accepts every masked channel.
// [RULE11] Otherwise accept only the selected channel.
// [RULE12] Software enables multi-channel in one context.
// [RULE13] Run is software owned, reset clears it.
// [RULE14] Wake resumes; descriptor fetch clears wake.
// [RULE15] Fatal error sets dead; run clear clears.
// [RULE16] Active shows descriptor processing, resets zero.
// [RULE17] Speed field reports receive rate code.
// [RULE18] Pack mode reports only four completion codes.
// [RULE19] Pack mode backs out bad packets silently.
// [RULE20] Per-packet mode reports seven completion codes.
// [RULE21] Set and clear addresses, identical reads.
// [RULE22] Eight contexts at a 20h stride.
// [RULE23] Reserved control bits read zero, ignore writes.
// Assumes a synchronous register port, one header word flagged by rx_sop per
// packet followed by at least one payload word, the last flagged by rx_eop.
`timescale 1ns/1ps
`include "irc_defs.svh"
module irc_core #(
    parameter int NCTX = 8
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // Register port
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [11:0]       reg_addr,
    input  wire logic [31:0]       reg_wdata,
    output logic      [31:0]       reg_rdata,
    // Bus timing and channel selection
    input  wire logic [31:0]       bus_cycle_timer,
    input  wire logic [15:0]       cycle_start_time,
    input  wire logic [31:0]       channel_select_mask_high,
    input  wire logic [31:0]       channel_select_mask_low,
    input  wire logic [NCTX*15-1:0] start_cycle_value,
    input  wire logic [NCTX*6-1:0] match_channel,
    // Descriptor engine
    input  wire logic [NCTX-1:0]   desc_fetch,
    input  wire logic              dma_err_valid,
    input  wire logic [2:0]        dma_err_ctx,
    input  wire logic [1:0]        dma_err_kind,
    // Link receive stream
    input  wire logic              rx_valid,
    input  wire logic              rx_sop,
    input  wire logic              rx_eop,
    input  wire logic [31:0]       rx_data,
    input  wire logic [2:0]        rx_spd,
    input  wire logic              rx_data_error,
    input  wire logic              rx_overrun,
    input  wire logic              rx_long,
    // Host memory write stream
    output logic                   out_valid,
    output logic      [31:0]       out_data,
    output logic      [2:0]        out_ctx,
    output logic                   out_pkt_end,
    output logic                   out_buf_close,
    output logic                   out_backout,
    // Context status
    output logic      [NCTX-1:0]   ctx_active,
    output logic      [NCTX-1:0]   ctx_run
);
    irc_ctx_if cif[NCTX] ();

    irc_pkg::irc_state_t state_reg;
    logic [31:0]    ctrl_w [NCTX];
    logic [NCTX-1:0] take;
    logic [NCTX-1:0] hit_reg;
    logic            sel_reg;
    logic [2:0]      sel_ctx_reg;
    logic            sel_pack_reg;
    logic            sel_keep_reg;
    logic            hdr_out_reg;
    logic            done_reg;
    logic [2:0]      done_ctx_reg;
    logic [2:0]      done_spd_reg;
    logic [4:0]      done_evt_reg;
    logic            pick_ok;
    logic [2:0]      pick_ctx;
    logic [4:0]      evt_now;
    logic            bad_now;
    logic            reg_hit;
    logic [4:0]      fatal_code;

    // Channel enabled in the multi-channel masks.
    function automatic logic chan_masked(input logic [5:0] ch, input logic [31:0] hi,
                                         input logic [31:0] lo);
        chan_masked = ch[5] ? hi[ch[4:0]] : lo[ch[4:0]];
    endfunction

    assign reg_hit = (reg_addr[11:8] == `IRC_REGION) &&
                     (reg_addr[4:0] == `IRC_SET_OFS || reg_addr[4:0] == `IRC_CLR_OFS);
    assign fatal_code = (dma_err_kind == 2'h0) ? `IRC_EVT_DESC_RD :
                        (dma_err_kind == 2'h1) ? `IRC_EVT_DATA_WR : `IRC_EVT_UNKNOWN;

    // ------------------------------------------------------------------
    // Per-context wiring
    // ------------------------------------------------------------------
    for (genvar i = 0; i < NCTX; i++) begin : g_ctx
        irc_ctx u_ctx (
            .clk     (clk),
            .reset_n (reset_n),
            .bus     (cif[i])
        );
        // Context i answers at 400h + 20h*i.
        assign cif[i].sw_set = reg_wr && reg_hit && (reg_addr[7:5] == 3'(i)) &&
                               (reg_addr[4:0] == `IRC_SET_OFS); // [RULE21] [RULE22]
        assign cif[i].sw_clr = reg_wr && reg_hit && (reg_addr[7:5] == 3'(i)) &&
                               (reg_addr[4:0] == `IRC_CLR_OFS); // [RULE21] [RULE22]
        assign cif[i].wdata      = reg_wdata;
        assign cif[i].desc_fetch = desc_fetch[i];
        assign cif[i].fatal      = dma_err_valid && (dma_err_ctx == 3'(i));
        assign cif[i].fatal_code = fatal_code;
        assign cif[i].pkt_done   = done_reg && (done_ctx_reg == 3'(i));
        assign cif[i].pkt_spd    = done_spd_reg;
        assign cif[i].pkt_evt    = done_evt_reg;
        assign cif[i].cycle_hit  = hit_reg[i];
        assign ctrl_w[i]         = cif[i].ctrl;
        // Channel acceptance for a header word now on the stream.
        assign take[i] = ctrl_w[i][`IRC_B_ACTIVE] &&
            (ctrl_w[i][`IRC_B_MULTI] ?
             chan_masked(rx_data[13:8], channel_select_mask_high,
                         channel_select_mask_low) :             // [RULE10]
             (rx_data[13:8] == match_channel[i*6 +: 6]));       // [RULE11]
    end

    // ------------------------------------------------------------------
    // Start cycle compare
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hit_reg <= '0;
        end else begin
            for (int k = 0; k < NCTX; k++) begin
                hit_reg[k] <= (bus_cycle_timer[26:12] == start_cycle_value[k*15 +: 15]); // [RULE8]
            end
        end
    end

    // ------------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata <= reg_hit ? (ctrl_w[reg_addr[7:5]] & `IRC_RD_MASK)
                                 : 32'h00000000; // [RULE21] [RULE23]
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctx_active <= '0;
            ctx_run    <= '0;
        end else begin
            for (int k = 0; k < NCTX; k++) begin
                ctx_active[k] <= ctrl_w[k][`IRC_B_ACTIVE];
                ctx_run[k]    <= ctrl_w[k][`IRC_B_RUN];
            end
        end
    end

    // ------------------------------------------------------------------
    // Context selection and completion code
    // ------------------------------------------------------------------
    always_comb begin
        pick_ok  = 1'b0;
        pick_ctx = 3'h0;
        for (int k = NCTX - 1; k >= 0; k--) begin
            if (take[k]) begin
                pick_ok  = 1'b1;
                pick_ctx = 3'(k);
            end
        end
    end

    assign bad_now = rx_data_error || rx_overrun;

    always_comb begin
        evt_now = `IRC_ACK_COMPLETE; // [RULE18]
        if (!sel_pack_reg) begin
            if (rx_data_error) begin
                evt_now = `IRC_ACK_DATA_ERR; // [RULE20]
            end else if (rx_overrun) begin
                evt_now = `IRC_EVT_OVERRUN; // [RULE20]
            end else if (rx_long) begin
                evt_now = `IRC_EVT_LONG; // [RULE20]
            end
        end
    end

    // ------------------------------------------------------------------
    // Receive steering
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg    <= irc_pkg::IRC_IDLE;
            sel_reg      <= 1'b0;
            sel_ctx_reg  <= 3'h0;
            sel_pack_reg <= 1'b0;
            sel_keep_reg <= 1'b0;
        end else begin
            case (state_reg)
                irc_pkg::IRC_IDLE: begin
                    if (rx_valid && rx_sop) begin
                        sel_reg      <= pick_ok;
                        sel_ctx_reg  <= pick_ctx;
                        sel_pack_reg <= ctrl_w[pick_ctx][`IRC_B_PACK];
                        sel_keep_reg <= ctrl_w[pick_ctx][`IRC_B_KEEP];
                        state_reg    <= irc_pkg::IRC_BODY;
                    end
                end
                irc_pkg::IRC_BODY: begin
                    if (rx_valid && rx_eop) begin
                        if (sel_reg && sel_keep_reg && !(sel_pack_reg && bad_now)) begin
                            state_reg <= irc_pkg::IRC_TRAIL; // [RULE6]
                        end else begin
                            state_reg <= irc_pkg::IRC_IDLE;
                        end
                    end
                end
                irc_pkg::IRC_TRAIL: begin
                    state_reg <= irc_pkg::IRC_IDLE;
                end
                default: begin
                    state_reg <= irc_pkg::IRC_IDLE;
                end
            endcase
        end
    end

    // Status is posted at the end of each delivered packet.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            done_reg     <= 1'b0;
            done_ctx_reg <= 3'h0;
            done_spd_reg <= `IRC_SPD_S100;
            done_evt_reg <= `IRC_ACK_COMPLETE;
        end else begin
            done_reg <= state_reg == irc_pkg::IRC_BODY && rx_valid && rx_eop && sel_reg &&
                        !(sel_pack_reg && bad_now); // [RULE19]
            if (state_reg == irc_pkg::IRC_BODY && rx_valid && rx_eop) begin
                done_ctx_reg <= sel_ctx_reg;
                done_spd_reg <= rx_spd; // [RULE17]
                done_evt_reg <= evt_now;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            out_valid     <= 1'b0;
            out_data      <= 32'h00000000;
            out_ctx       <= 3'h0;
            out_pkt_end   <= 1'b0;
            out_buf_close <= 1'b0;
            out_backout   <= 1'b0;
            hdr_out_reg   <= 1'b0;
        end else begin
            out_valid     <= 1'b0;
            out_pkt_end   <= 1'b0;
            out_buf_close <= 1'b0;
            out_backout   <= 1'b0;
            hdr_out_reg   <= 1'b0;
            case (state_reg)
                irc_pkg::IRC_IDLE: begin
                    if (rx_valid && rx_sop && pick_ok && ctrl_w[pick_ctx][`IRC_B_KEEP]) begin
                        out_valid   <= 1'b1; // [RULE5]
                        out_data    <= rx_data;
                        out_ctx     <= pick_ctx;
                        hdr_out_reg <= 1'b1;
                    end
                end
                irc_pkg::IRC_BODY: begin
                    if (rx_valid && sel_reg) begin
                        out_valid <= 1'b1; // [RULE7]
                        out_data  <= rx_data;
                        out_ctx   <= sel_ctx_reg;
                        if (rx_eop) begin
                            out_backout   <= sel_pack_reg && bad_now; // [RULE19]
                            out_pkt_end   <= !sel_keep_reg || (sel_pack_reg && bad_now);
                            out_buf_close <= !sel_pack_reg && !sel_keep_reg; // [RULE1] [RULE2]
                        end
                    end
                end
                irc_pkg::IRC_TRAIL: begin
                    out_valid     <= 1'b1; // [RULE6]
                    out_data      <= {ctrl_w[sel_ctx_reg][15:8], done_spd_reg, done_evt_reg,
                                      cycle_start_time};
                    out_ctx       <= sel_ctx_reg;
                    out_pkt_end   <= 1'b1;
                    out_buf_close <= !sel_pack_reg; // [RULE2]
                end
                default: begin
                    out_valid <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n) // [RULE23]
        (reg_rdata[27:16] == 12'h000) && (reg_rdata[14:13] == 2'b00) &&
        (reg_rdata[9:8] == 2'b00))
        else $error("reserved control bits read nonzero");
    a_header_kept: assert property (@(posedge clk) disable iff (!reset_n) // [RULE5]
        hdr_out_reg |-> out_valid && ctrl_w[out_ctx][`IRC_B_KEEP])
        else $error("header stored without keep-header");
    a_trailer_follows: assert property (@(posedge clk) disable iff (!reset_n) // [RULE6]
        (state_reg == irc_pkg::IRC_TRAIL) |=>
        out_valid && out_pkt_end && (out_data[15:0] == $past(cycle_start_time)))
        else $error("trailer word missing or wrong cycle_start_time");
    a_pack_no_close: assert property (@(posedge clk) disable iff (!reset_n) // [RULE1]
        (out_valid && ctrl_w[out_ctx][`IRC_B_PACK]) |-> !out_buf_close)
        else $error("pack mode closed a buffer per packet");
    a_pack_codes: assert property (@(posedge clk) disable iff (!reset_n) // [RULE18]
        (done_reg && ctrl_w[done_ctx_reg][`IRC_B_PACK]) |-> done_evt_reg == `IRC_ACK_COMPLETE)
        else $error("illegal completion code in pack mode");
    a_backout_quiet: assert property (@(posedge clk) disable iff (!reset_n) // [RULE19]
        out_backout |-> !done_reg ##1 !done_reg)
        else $error("backed out packet updated status");
    a_speed_post: assert property (@(posedge clk) disable iff (!reset_n) // [RULE17]
        done_reg |=> ctrl_w[$past(done_ctx_reg)][7:5] == $past(done_spd_reg))
        else $error("received speed not reported");
endmodule

/* verification/irc_link_model.sv */
// Link receive path model: one header word, one payload word per packet.
// Assumes the bench calls send() from its clocked sequence.
`timescale 1ns/1ps
module irc_link_model (
    // Clock
    input wire logic clk,
    // Receive stream
    output logic        rx_valid,
    output logic        rx_sop,
    output logic        rx_eop,
    output logic [31:0] rx_data,
    output logic [2:0]  rx_spd,
    output logic        rx_data_error,
    output logic        rx_overrun,
    output logic        rx_long
);
    initial {rx_valid, rx_sop, rx_eop, rx_data, rx_spd, rx_data_error, rx_overrun, rx_long} = '0;
    task automatic send(input logic [31:0] hdr, pay, input logic [2:0] spd, input logic err);
        @(posedge clk);
        #1 {rx_valid, rx_sop, rx_data} = {2'b11, hdr};
        @(posedge clk);
        #1 {rx_sop, rx_eop, rx_data, rx_spd, rx_data_error} = {2'b01, pay, spd, err};
        @(posedge clk);
        // A released line shows the inverse of its last word.
        #1 {rx_valid, rx_eop, rx_data, rx_data_error} = {2'b00, ~pay, 1'b0};
    endtask
endmodule

/* verification/irc_core_tb_top.sv */
// Bench for irc_core: register reads and writes plus receive traffic.
// Assumes irc_link_model stands in for the link receive path.
`timescale 1ns/1ps
module irc_core_tb_top;
    logic         clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, dma_err_valid = 0;
    logic [11:0]  reg_addr = '0;
    logic [31:0]  reg_wdata = '0, reg_rdata, out_data, rx_data, bus_cycle_timer = '0;
    logic [31:0]  channel_select_mask_high = '0, channel_select_mask_low = '0;
    logic [15:0]  cycle_start_time = 16'hA5C3;
    logic [119:0] start_cycle_value = '0;
    logic [47:0]  match_channel = 48'h5;
    logic [7:0]   desc_fetch = '0, ctx_active, ctx_run;
    logic [2:0]   dma_err_ctx = '0, out_ctx, rx_spd;
    logic [1:0]   dma_err_kind = 2'h1;
    logic         rx_valid, rx_sop, rx_eop, rx_data_error, rx_overrun, rx_long;
    logic         out_valid, out_pkt_end, out_buf_close, out_backout;
    logic [31:0]  q[$];
    logic [5:0]   f[$];
    int           error_cnt = 0, samples_checked = 0, cyc = 0;
    always #4 clk = ~clk;
    always @(posedge clk) if (out_valid === 1'b1) q.push_back(out_data);
    always @(posedge clk)
        if (out_valid === 1'b1) f.push_back({out_ctx, out_pkt_end, out_buf_close, out_backout});
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            test_done();
        end
    end
    irc_core u_irc_core (.clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .bus_cycle_timer, .cycle_start_time, .channel_select_mask_high, .channel_select_mask_low,
        .start_cycle_value, .match_channel, .desc_fetch, .dma_err_valid, .dma_err_ctx,
        .dma_err_kind, .rx_valid, .rx_sop, .rx_eop, .rx_data, .rx_spd, .rx_data_error,
        .rx_overrun, .rx_long, .out_valid, .out_data, .out_ctx, .out_pkt_end, .out_buf_close,
        .out_backout, .ctx_active, .ctx_run);
    irc_link_model u_irc_link_model (.clk, .rx_valid, .rx_sop, .rx_eop, .rx_data, .rx_spd,
        .rx_data_error, .rx_overrun, .rx_long);
    task automatic test_done();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(posedge clk);
        #1 reg_wr = 0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        #1 {reg_rd, reg_addr} = {1'b1, a};
        @(posedge clk);
        #1 reg_rd = 0;
        @(posedge clk);
        #1 check(reg_rdata, e);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        #1 reset_n = 1;
        rd(12'h400, 32'h0);
        rd(12'h408, 32'h0);
        wr(12'h420, 32'hFFFF_6FFF);
        rd(12'h424, 32'hF000_001F);
        wr(12'h424, 32'hFFFF_FFFF);
        rd(12'h420, 32'h0);
        wr(12'h440, 32'h0000_1000);
        rd(12'h444, 32'h0000_1000);
        @(posedge clk);
        #1 desc_fetch = 8'h04;
        @(posedge clk);
        #1 desc_fetch = 8'h00;
        rd(12'h440, 32'h0);
        wr(12'h400, 32'h4000_8000);
        repeat (4) @(posedge clk);
        rd(12'h404, 32'h4000_8400);
        check({ctx_run, ctx_active}, 16'h0101);
        u_irc_link_model.send(32'h0000_0500, 32'hCAFE_0001, 3'h2, 1'b0);
        u_irc_link_model.send(32'h0000_0600, 32'h1234_5678, 3'h1, 1'b0);
        repeat (4) @(posedge clk);
        check(32'(q.size()), 32'd3);
        check(q[0], 32'h0000_0500);
        check(q[2], 32'h8451_A5C3);
        check(f[2], 6'h06);
        rd(12'h400, 32'h4000_8451);
        @(posedge clk);
        #1 dma_err_valid = 1;
        @(posedge clk);
        #1 dma_err_valid = 0;
        rd(12'h400, 32'h4000_8848);
        check({ctx_run, ctx_active}, 16'h0100);
        wr(12'h404, 32'h4000_8000);
        rd(12'h400, 32'h0000_0048);
        wr(12'h400, 32'h8000_8000);
        repeat (4) @(posedge clk);
        q.delete();
        f.delete();
        u_irc_link_model.send(32'h0000_0500, 32'hBEEF_0002, 3'h0, 1'b0);
        u_irc_link_model.send(32'h0000_0500, 32'h0BAD_0003, 3'h1, 1'b1);
        repeat (4) @(posedge clk);
        check(q[0], 32'hBEEF_0002);
        check(f[1], 6'h05);
        rd(12'h400, 32'h8000_8411);
        start_cycle_value[45 +: 15] = 15'h0012;
        channel_select_mask_high = 32'h1;
        wr(12'h460, 32'hB000_8000);
        rd(12'h464, 32'hB000_8000);
        bus_cycle_timer = 32'h0001_2000;
        repeat (2) @(posedge clk);
        rd(12'h460, 32'h9000_8400);
        check({ctx_run, ctx_active}, 16'h0909);
        u_irc_link_model.send(32'h0000_2000, 32'h5EED_0004, 3'h2, 1'b0);
        repeat (4) @(posedge clk);
        check(q[2], 32'h5EED_0004);
        check(f[2], 6'h1C);
        test_done();
    end
endmodule
